// ### design/irq_route_pkg.sv
// Constants, types and register map for the routed interrupt and clock-run block.
package irq_route_pkg;
   localparam int ADDR_W   = 4;
   localparam int DATA_W   = 8;
   localparam int NUM_IRQ  = 16;
   localparam int CNT_W    = 6;
   localparam int LOW_W    = 4;

   // Register offsets.
   localparam logic [ADDR_W-1:0] ADDR_ROUTE_FIRST  = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_ROUTE_SECOND = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_EVT_CTL      = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_EVT_STS      = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_STATUS       = 4'h4;

   // Field positions.
   localparam int SEL_LSB  = 0;
   localparam int SEL_W    = 4;
   localparam int EN_BIT   = 7;
   localparam int POL_LSB  = 0;
   localparam int PME_LSB  = 2;
   localparam int SMI_LSB  = 4;
   localparam int ST_DRIVE = 0;
   localparam int ST_QUIET = 1;
   localparam int ST_PEND  = 2;

   // Reset values.
   localparam logic [DATA_W-1:0] ROUTE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] EVT_RESET   = 8'h00;
   localparam logic [SEL_W-1:0]  SEL_OFF     = 4'h0;

   // Timing counts in bus clocks.
   localparam logic [CNT_W-1:0] SYNC_LAG   = 6'h02;
   localparam logic [CNT_W-1:0] FRAME_CLKS = 6'h03;
   localparam logic [CNT_W-1:0] SAMPLE_OFS = 6'h02;
   localparam logic [CNT_W-1:0] FRAME_END  = 6'h33;
   localparam logic [1:0]       HOLD_EDGES = 2'h2;
   localparam logic [1:0]       HIGH_MIN   = 2'h2;
   localparam logic [LOW_W-1:0] QUIET_LOW  = 4'h2;

   typedef enum {S_IDLE, S_START, S_ACTIVE, S_FRAMES, S_STOP} sirq_state_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;
endpackage : irq_route_pkg

// ### design/irq_route_clkrun.sv
// Routed interrupt inputs, serial interrupt slave and clock-run request.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module irq_route_clkrun
   import irq_route_pkg::*;
(
   input  wire logic              MCLK_I,        // Bus clock.
   input  wire logic              RST_B_I,       // Bus reset, active low.
   input  wire logic [ADDR_W-1:0] REG_ADDR_I,    // Register address.
   input  wire logic [DATA_W-1:0] REG_WDATA_I,   // Register write data.
   input  wire logic              REG_WR_I,      // Write strobe.
   input  wire logic              REG_RD_I,      // Read strobe.
   output logic       [DATA_W-1:0] REG_RDATA_O,  // Read data, next cycle.
   input  wire logic              ROUTED_IRQ_FIRST_I,  // First routed pin.
   input  wire logic              ROUTED_IRQ_SECOND_I, // Second routed pin.
   input  wire logic [NUM_IRQ-1:0] INT_IRQ_I,     // Internal IRQ levels.
   input  wire logic [NUM_IRQ-1:0] INT_IRQ_USED_I,// IRQs owned inside.
   input  wire logic              DRQ_I,         // Internal DMA request.
   output logic                   LDRQ_GO_O,     // DMA request may drive.
   output logic                   PME_O,         // Wake event, high.
   output logic                   SMI_O,         // Management irq, high.
   input  wire logic              CLKRUN_I,      // Clock-run line level.
   output logic                   CLKRUN_O,      // Clock-run drive value.
   output logic                   CLKRUN_OE_O,   // Clock-run drive enable.
   input  wire logic              SERIRQ_I,      // Serial irq line level.
   output logic                   SERIRQ_O,      // Serial irq drive value.
   output logic                   SERIRQ_OE_O    // Serial irq drive enable.
);
   //--------------------------------------------------------------------
   // Functions
   //--------------------------------------------------------------------
   function automatic logic [NUM_IRQ-1:0] route_vec(
      input logic [SEL_W-1:0] sel_a, input logic pin_a,
      input logic [SEL_W-1:0] sel_b, input logic pin_b);
      logic [NUM_IRQ-1:0] v;
      v = '0;
      if (sel_a != SEL_OFF) v[sel_a] = pin_a;
      if (sel_b != SEL_OFF) v[sel_b] = v[sel_b] | pin_b;
      return v;
   endfunction : route_vec

   function automatic logic [NUM_IRQ-1:0] route_mask(
      input logic [SEL_W-1:0] sel_a, input logic [SEL_W-1:0] sel_b);
      logic [NUM_IRQ-1:0] m;
      m = '0;
      if (sel_a != SEL_OFF) m[sel_a] = 1'b1;
      if (sel_b != SEL_OFF) m[sel_b] = 1'b1;
      return m;
   endfunction : route_mask

   function automatic logic [CNT_W-1:0] slot_of(input int n);
      return CNT_W'(n) * FRAME_CLKS + SAMPLE_OFS;
   endfunction : slot_of

   //--------------------------------------------------------------------
   // Reset release and input synchronisers
   //--------------------------------------------------------------------
   logic              rst_m_q, rst_n_q;
   logic [1:0]        pin_m_q, pin_s_q, pin_p_q;
   logic [NUM_IRQ-1:0] irq_m_q, irq_s_q;
   logic              drq_m_q, drq_s_q;
   logic              ck_m_q, ck_s_q, sq_m_q, sq_s_q, sq_p_q;
   logic              pend_m_q, pend_s_q;
   logic              pend_raw;

   always_ff @(posedge MCLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_m_q  <= '0;
         pin_s_q  <= '0;
         pin_p_q  <= '0;
         irq_m_q  <= '0;
         irq_s_q  <= '0;
         drq_m_q  <= 1'b0;
         drq_s_q  <= 1'b0;
         ck_m_q   <= 1'b0;
         ck_s_q   <= 1'b0;
         sq_m_q   <= 1'b1;
         sq_s_q   <= 1'b1;
         sq_p_q   <= 1'b1;
         pend_m_q <= 1'b0;
         pend_s_q <= 1'b0;
      end else begin
         pin_m_q  <= {ROUTED_IRQ_SECOND_I, ROUTED_IRQ_FIRST_I};
         pin_s_q  <= pin_m_q;
         pin_p_q  <= pin_s_q;
         irq_m_q  <= INT_IRQ_I;
         irq_s_q  <= irq_m_q;
         drq_m_q  <= DRQ_I;
         drq_s_q  <= drq_m_q;
         ck_m_q   <= CLKRUN_I;
         ck_s_q   <= ck_m_q;
         sq_m_q   <= SERIRQ_I;
         sq_s_q   <= sq_m_q;
         sq_p_q   <= sq_s_q;
         pend_m_q <= pend_raw;
         pend_s_q <= pend_m_q;
      end
   end

   //--------------------------------------------------------------------
   // Register file
   //--------------------------------------------------------------------
   reg_req_t          req;
   logic [DATA_W-1:0] route_a_q, route_b_q, evt_ctl_q, rdata_q;
   logic [1:0]        evt_sts_q;
   logic              en, quiet_q, hold_q;
   logic [SEL_W-1:0]  sel_a, sel_b;

   assign req   = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I,
                    wdata: REG_WDATA_I};
   assign en    = route_a_q[EN_BIT];
   assign sel_a = route_a_q[SEL_LSB +: SEL_W];
   assign sel_b = route_b_q[SEL_LSB +: SEL_W];

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         route_a_q <= ROUTE_RESET;
         route_b_q <= ROUTE_RESET;
         evt_ctl_q <= EVT_RESET;
      end else if (req.wr) begin
         if (req.addr == ADDR_ROUTE_FIRST)  route_a_q <= req.wdata;
         if (req.addr == ADDR_ROUTE_SECOND) route_b_q <= req.wdata;
         if (req.addr == ADDR_EVT_CTL)      evt_ctl_q <= req.wdata;
      end
   end

   // Unmapped addresses read as zero.
   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= '0;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_ROUTE_FIRST:  rdata_q <= route_a_q;
            ADDR_ROUTE_SECOND: rdata_q <= route_b_q;
            ADDR_EVT_CTL:      rdata_q <= evt_ctl_q;
            ADDR_EVT_STS:      rdata_q <= {6'h00, evt_sts_q};
            ADDR_STATUS:       rdata_q <= {5'h00, pend_s_q, quiet_q,
                                           hold_q};
            default:           rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end
   assign REG_RDATA_O = rdata_q;

   //--------------------------------------------------------------------
   // Pin edge events (status is write-one-to-clear, set wins)
   //--------------------------------------------------------------------
   logic [1:0] evt, pol, sts_clr;
   logic       pme_q, smi_q;

   assign pol     = evt_ctl_q[POL_LSB +: 2];
   assign evt     = (pin_s_q & ~pin_p_q & ~pol)
                  | (~pin_s_q & pin_p_q & pol);
   assign sts_clr = (req.wr && req.addr == ADDR_EVT_STS) ?
                    req.wdata[1:0] : 2'b00;

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         evt_sts_q <= '0;
         pme_q     <= 1'b0;
         smi_q     <= 1'b0;
      end else begin
         evt_sts_q <= evt | (evt_sts_q & ~sts_clr);
         pme_q     <= |(evt_sts_q & evt_ctl_q[PME_LSB +: 2]);
         smi_q     <= |(evt_sts_q & evt_ctl_q[SMI_LSB +: 2]);
      end
   end
   assign PME_O = pme_q;
   assign SMI_O = smi_q;

   //--------------------------------------------------------------------
   // Change detection
   //--------------------------------------------------------------------
   // The compare works without a clock, so a change is seen while the
   // bus clock is stopped; it only clears once the slot carried it.
   logic [NUM_IRQ-1:0] sent_q, lvl_raw, lvl_s, used;
   logic               drq_done_q, dma_ok_q;

   assign used    = INT_IRQ_USED_I | route_mask(sel_a, sel_b);
   // Internal levels of slots this device does not own must not mask a
   // routed pin, or the pin state would never reach the stream.
   assign lvl_raw = (INT_IRQ_I & INT_IRQ_USED_I)
                  | route_vec(sel_a, ROUTED_IRQ_FIRST_I,
                              sel_b, ROUTED_IRQ_SECOND_I);
   assign lvl_s   = (irq_s_q & INT_IRQ_USED_I)
                  | route_vec(sel_a, pin_s_q[0], sel_b, pin_s_q[1]);
   assign pend_raw = |((lvl_raw ^ sent_q) & used)
                   | (DRQ_I & ~drq_done_q);

   // A DMA request may drive only once the clock is seen running.
   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         drq_done_q <= 1'b0;
         dma_ok_q   <= 1'b0;
      end else begin
         dma_ok_q   <= drq_s_q & ~ck_s_q;
         if (!drq_s_q) drq_done_q <= 1'b0;
         else if (dma_ok_q) drq_done_q <= 1'b1;
      end
   end
   assign LDRQ_GO_O = dma_ok_q;

   //--------------------------------------------------------------------
   // Clock-run request
   //--------------------------------------------------------------------
   logic [1:0] high_cnt_q, hold_cnt_q;
   logic       armed, ck_oe;

   assign armed = (high_cnt_q == HIGH_MIN) & ck_s_q;
   assign ck_oe = rst_n_q & en
                & ((pend_raw & armed) | hold_q);

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         high_cnt_q <= '0;
      end else if (ck_oe || !ck_s_q) begin
         high_cnt_q <= '0;
      end else if (high_cnt_q != HIGH_MIN) begin
         high_cnt_q <= high_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         hold_q     <= 1'b0;
         hold_cnt_q <= '0;
      end else if (!ck_oe) begin
         hold_q     <= 1'b0;
         hold_cnt_q <= '0;
      end else if (hold_cnt_q == HOLD_EDGES - 2'h1) begin
         hold_q     <= 1'b0;
         hold_cnt_q <= '0;
      end else begin
         hold_q     <= 1'b1;
         hold_cnt_q <= hold_cnt_q + 2'h1;
      end
   end
   assign CLKRUN_O    = 1'b0;
   assign CLKRUN_OE_O = ck_oe;

   //--------------------------------------------------------------------
   // Serial interrupt slave
   //--------------------------------------------------------------------
   sirq_state_t        state_q;
   logic [CNT_W-1:0]   cnt_q, cnt_nx;
   logic [LOW_W-1:0]   low_q;
   logic               sq_oe_q, start_go, in_slots;
   logic [NUM_IRQ-1:0] hit;

   assign start_go = quiet_q & pend_s_q & sq_s_q & sq_p_q & en;
   assign in_slots = (state_q == S_FRAMES)
                   | ((state_q == S_ACTIVE) & sq_s_q);
   assign cnt_nx   = (state_q == S_ACTIVE) ? SYNC_LAG : cnt_q + 6'h01;

   for (genvar n = 0; n < NUM_IRQ; n++) begin : g_slot
      assign hit[n] = in_slots & (cnt_nx == slot_of(n)) & used[n];
   end

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sent_q <= '0;
      end else begin
         for (int n = 0; n < NUM_IRQ; n++) begin
            if (hit[n]) sent_q[n] <= lvl_s[n];
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sq_oe_q <= 1'b0;
      end else begin
         sq_oe_q <= en & (((state_q == S_IDLE) & start_go)
                        | |(hit & ~lvl_s));
      end
   end

   always_ff @(posedge MCLK_I or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= S_IDLE;
         cnt_q   <= '0;
         low_q   <= '0;
         quiet_q <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (!sq_s_q) state_q <= S_ACTIVE;
               else if (start_go) state_q <= S_START;
            end
            S_START: if (!sq_s_q) state_q <= S_ACTIVE;
            S_ACTIVE: begin
               if (sq_s_q) begin
                  state_q <= S_FRAMES;
                  cnt_q   <= cnt_nx;
               end
            end
            S_FRAMES: begin
               cnt_q <= cnt_nx;
               if (cnt_nx == FRAME_END) begin
                  state_q <= S_STOP;
                  low_q   <= '0;
               end
            end
            S_STOP: begin
               if (!sq_s_q) begin
                  low_q <= low_q + 4'h1;
               end else if (low_q != '0) begin
                  quiet_q <= (low_q == QUIET_LOW);
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
   assign SERIRQ_O    = 1'b0;
   assign SERIRQ_OE_O = sq_oe_q;

   //--------------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!rst_n_q);

   a_clkrun_needs_en: assert property (CLKRUN_OE_O |-> en)
      else $error("Clock-run driven with restart disabled.");
   a_serirq_needs_en: assert property (SERIRQ_OE_O |-> $past(en))
      else $error("Serial irq driven with restart disabled.");
   a_clkrun_armed: assert property (
      (CLKRUN_OE_O && !hold_q) |-> (high_cnt_q == HIGH_MIN))
      else $error("Clock-run asserted without two high clocks.");
   a_clkrun_line_high: assert property (
      (CLKRUN_OE_O && !hold_q) |-> ck_s_q && $past(ck_s_q))
      else $error("Clock-run asserted while line was low.");
   a_hold_two_edges: assert property (
      (CLKRUN_OE_O && !hold_q) |=> ((hold_q && CLKRUN_OE_O) || !en)
      ##1 !hold_q)
      else $error("Clock-run not held for two edges.");
   a_slot_one_clock: assert property (
      (SERIRQ_OE_O && state_q == S_FRAMES) |=> !SERIRQ_OE_O)
      else $error("Serial irq slot drive longer than one clock.");
   a_quiet_start: assert property (
      $rose(state_q == S_START) |-> SERIRQ_OE_O ##1 !SERIRQ_OE_O)
      else $error("Start frame drive not exactly one clock.");
   a_routed_slot: assert property (
      (en && state_q == S_FRAMES && sel_a != SEL_OFF && !pin_s_q[0]
       && cnt_nx == slot_of(int'(sel_a))) |=> SERIRQ_OE_O)
      else $error("Routed pin low but its slot was not driven.");
   a_pin_event: assert property (
      evt[0] |=> evt_sts_q[0])
      else $error("Routed pin edge did not set its status.");

   c_quiet_start: cover property (state_q == S_START);
   c_clkrun_req:  cover property ($rose(hold_q));
   c_stop_quiet:  cover property ($rose(quiet_q));
endmodule : irq_route_clkrun

// ### testbench/sirq_host_model.sv
// Far-side model: bus clock run control and serial interrupt host.
`timescale 1ns/100ps
module sirq_host_model (
   input  wire logic        clk_i,         // Bus clock.
   input  wire logic        stop_i,        // Pulse: stop the bus clock.
   input  wire logic        frame_i,       // Pulse: run one serial cycle.
   input  wire logic [1:0]  stop_w_i,      // Stop frame low clocks.
   input  wire logic        clkrun_oe_i,   // Device pulls clock-run low.
   input  wire logic        serirq_oe_i,   // Device pulls serial low.
   output logic             clkrun_line_o, // Resolved clock-run line.
   output logic             serirq_line_o, // Resolved serial line.
   output logic [15:0]      slots_o,       // Slots seen low.
   output logic             done_o         // Cycle finished.
);
   logic run_q    = 1'b1;
   logic host_drv = 1'b0;
   int   k;
   // Both lines have pull-ups, so a released line reads high.
   assign clkrun_line_o = ~(run_q | clkrun_oe_i);
   assign serirq_line_o = ~(host_drv | serirq_oe_i);
   // A low seen while stopped restarts the clock and keeps it low.
   always @(posedge clk_i) begin
      if (stop_i)
         run_q <= 1'b0;
      else if (!clkrun_line_o)
         run_q <= 1'b1;
   end
   initial done_o = 1'b1;
   initial slots_o = '0;
   // Slots are judged one clock either side of the nominal sample point.
   // A start frame from the device opens a cycle just as the host does.
   always @(posedge frame_i or posedge serirq_oe_i) begin
      done_o = 1'b0;
      slots_o = '0;
      @(posedge clk_i) host_drv <= 1'b1;
      repeat (4) @(posedge clk_i);
      host_drv <= 1'b0;
      for (k = 1; k <= 51; k++) begin
         @(posedge clk_i);
         if (!serirq_line_o && k >= 2 && k <= 49)
            slots_o[(k - 2) / 3] = 1'b1;
      end
      host_drv <= 1'b1;
      repeat (stop_w_i) @(posedge clk_i);
      host_drv <= 1'b0;
      repeat (3) @(posedge clk_i);
      done_o = 1'b1;
   end
endmodule : sirq_host_model

// ### testbench/irq_route_clkrun_tb.sv
// Self-checking bench for the routed interrupt and clock-run block.
`timescale 1ns/100ps
module irq_route_clkrun_tb;
   import irq_route_pkg::*;
   logic               mclk = 1'b0;
   logic               rst_b = 1'b0;
   logic [ADDR_W-1:0]  addr = '0;
   logic [DATA_W-1:0]  wdata = '0;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic               pin1 = 1'b0;
   logic               pin2 = 1'b1;
   logic [NUM_IRQ-1:0] irq = 16'hFFF7;
   logic [NUM_IRQ-1:0] used = 16'h0008;
   logic               drq = 1'b0;
   logic               stop = 1'b0;
   logic               frame_go = 1'b0;
   logic [1:0]         stop_w = 2'h3;
   logic [DATA_W-1:0]  rdata;
   logic [DATA_W-1:0]  v;
   logic [15:0]        slots;
   logic               done, ldrq_go, pme, smi, ck_line, ck_o, ck_oe;
   logic               sq_line, sq_o, sq_oe;
   int                 n_mismatch = 0;
   int                 check_count = 0;
   int                 n;

   initial forever #5 mclk = ~mclk;

   irq_route_clkrun irq_route_clkrun_inst (
      .MCLK_I(mclk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .ROUTED_IRQ_FIRST_I(pin1),
      .ROUTED_IRQ_SECOND_I(pin2), .INT_IRQ_I(irq), .INT_IRQ_USED_I(used),
      .DRQ_I(drq), .LDRQ_GO_O(ldrq_go), .PME_O(pme), .SMI_O(smi),
      .CLKRUN_I(ck_line), .CLKRUN_O(ck_o), .CLKRUN_OE_O(ck_oe),
      .SERIRQ_I(sq_line), .SERIRQ_O(sq_o), .SERIRQ_OE_O(sq_oe));

   sirq_host_model sirq_host_model_inst (
      .clk_i(mclk), .stop_i(stop), .frame_i(frame_go), .stop_w_i(stop_w),
      .clkrun_oe_i(ck_oe), .serirq_oe_i(sq_oe), .clkrun_line_o(ck_line),
      .serirq_line_o(sq_line), .slots_o(slots), .done_o(done));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   // Runs one host serial cycle and compares the slots pulled low.
   task automatic frame(input logic [1:0] w, input logic [15:0] exp);
      int i;
      @(posedge mclk);
      stop_w <= w;
      frame_go <= 1'b1;
      @(posedge mclk);
      frame_go <= 1'b0;
      for (i = 0; i < 90 && done !== 1'b1; i++)
         @(posedge mclk);
      chk(done, 1'b1);
      chk(slots, exp);
   endtask : frame

   // Stops the bus clock and lets the line settle high long enough.
   task automatic halt();
      @(posedge mclk);
      stop <= 1'b1;
      @(posedge mclk);
      stop <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask : halt

   task automatic ob(input logic want, input int cnt);
      repeat (cnt) begin
         @(posedge mclk);
         #1 chk(ck_oe, want);
      end
   endtask : ob

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   function automatic logic [15:0] exp_slots(input int s, input logic p,
                                             input logic l3);
      exp_slots = (s != 0 && !p) ? (16'h0001 << s) : 16'h0000;
      if (!l3)
         exp_slots |= 16'h0008;
   endfunction : exp_slots

   initial begin
      #100000;
      n_mismatch++;
      complete_run();
   end

   initial begin
      void'($urandom(32'h67D7));
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rd_reg(ADDR_ROUTE_FIRST, v);
      chk(v, ROUTE_RESET);
      rd_reg(ADDR_ROUTE_SECOND, v);
      chk(v, ROUTE_RESET);
      rd_reg(4'hF, v);
      chk(v, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 5; i++) begin
         n = (i == 0) ? 15 : int'($urandom % 16);
         // Slot three is owned inside, so it is never routed.
         if (n == 3)
            n = 0;
         pin1 <= (i == 0) ? 1'b0 : 1'($urandom);
         wr_reg(ADDR_ROUTE_FIRST, 8'h80 | 8'(n));
         frame(2'h3, exp_slots(n, pin1, irq[3]));
      end
      wr_reg(ADDR_ROUTE_FIRST, 8'h80);
      pin1 <= 1'b0;
      frame(2'h3, 16'h0008);
      $display("test routing done");
      halt();
      chk(ck_oe, 1'b0);
      irq[3] <= 1'b1;
      #2 chk(ck_oe, 1'b1);
      ob(1'b1, 1);
      ob(1'b0, 1);
      frame(2'h3, 16'h0000);
      wr_reg(ADDR_ROUTE_FIRST, 8'h00);
      halt();
      irq[3] <= 1'b0;
      ob(1'b0, 8);
      wr_reg(ADDR_ROUTE_FIRST, 8'h80);
      #1 chk(ck_oe, 1'b1);
      frame(2'h3, 16'h0008);
      irq[3] <= 1'b1;
      ob(1'b0, 4);
      frame(2'h3, 16'h0000);
      wr_reg(ADDR_ROUTE_FIRST, 8'h00);
      irq[3] <= 1'b0;
      frame(2'h3, 16'h0000);
      wr_reg(ADDR_ROUTE_FIRST, 8'h80);
      frame(2'h3, 16'h0008);
      $display("test clock run done");
      frame(2'h2, 16'h0008);
      rd_reg(ADDR_STATUS, v);
      chk(v & 8'h02, 8'h02);
      stop_w <= 2'h3;
      irq[3] <= 1'b1;
      for (int i = 0; i < 20 && done === 1'b1; i++)
         @(posedge mclk);
      chk(done, 1'b0);
      for (int i = 0; i < 90 && done !== 1'b1; i++)
         @(posedge mclk);
      chk(slots, 16'h0000);
      rd_reg(ADDR_STATUS, v);
      chk(v & 8'h02, 8'h00);
      $display("test quiet done");
      halt();
      drq <= 1'b1;
      #2 chk({ck_oe, ldrq_go}, 2'b10);
      for (int i = 0; i < 10 && ldrq_go !== 1'b1; i++)
         @(posedge mclk);
      chk(ldrq_go, 1'b1);
      drq <= 1'b0;
      $display("test dma done");
      // Slot fields stay zero while the pins act as plain inputs.
      wr_reg(ADDR_EVT_CTL, 8'h26);
      wr_reg(ADDR_EVT_STS, 8'h03);
      pin1 <= 1'b1;
      repeat (6) @(posedge mclk);
      #1 chk({pme, smi}, 2'b10);
      pin2 <= 1'b0;
      repeat (6) @(posedge mclk);
      #1 chk({pme, smi}, 2'b11);
      rd_reg(ADDR_EVT_STS, v);
      chk(v, 8'h03);
      wr_reg(ADDR_EVT_STS, 8'h03);
      repeat (2) @(posedge mclk);
      #1 chk({pme, smi}, 2'b00);
      $display("test events done");
      halt();
      drq <= 1'b1;
      @(posedge mclk);
      rst_b <= 1'b0;
      #1 chk({ck_oe, sq_oe}, 2'b00);
      drq <= 1'b0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rd_reg(ADDR_ROUTE_FIRST, v);
      chk(v, ROUTE_RESET);
      $display("test reset done");
      complete_run();
   end
endmodule : irq_route_clkrun_tb
